/* design/sysopt_top.sv */
// System options register bank with watchdog window check and pin routing.
// Assumes a classic Wishbone master on clk_i; pins arrive asynchronously.
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module sysopt_top import sysopt_pkg::*; #(
	parameter int unsigned LP_TICK_CYCLES_P      = LP_TICK_CYCLES,
	parameter int unsigned WDOG_TIMEOUT_TICKS_P  = WDOG_TIMEOUT_DEFAULT
) (
	input  wire logic              clk_i,                    // Bus clock, 100 MHz
	input  wire logic              rst_i,                    // Synchronous reset
	input  wire logic              wb_cyc_i,                 // Bus cycle
	input  wire logic              wb_stb_i,                 // Bus strobe
	input  wire logic              wb_we_i,                  // Write enable
	input  wire logic [ADR_W-1:0]  wb_adr_i,                 // Byte address
	input  wire logic [3:0]        wb_sel_i,                 // Byte lanes
	input  wire logic [31:0]       wb_dat_i,                 // Write data
	output logic      [31:0]       wb_dat_o,                 // Read data
	output logic                   wb_ack_o,                 // Acknowledge
	output logic                   system_reset_o,           // Watchdog reset pulse
	output logic                   watchdog_clock_select_o,  // Current bit 7
	output logic                   watchdog_window_enable_o, // Current bit 6
	input  wire logic              analog_comparator_i,      // Comparator output, async
	input  wire logic [NUM_CH-1:0] tmr_out_i,                // Timer channel outputs
	input  wire logic [NUM_CH-1:0] tmr_oe_i,                 // Timer channel enables
	output logic      [NUM_CH-1:0] tmr_in_o,                 // Timer channel inputs
	input  wire logic [NUM_CH-1:0] pin_first_i,              // Pin level, first location
	input  wire logic [NUM_CH-1:0] pin_second_i,             // Pin level, second location
	output logic      [NUM_CH-1:0] pin_first_o,              // Pin drive, first location
	output logic      [NUM_CH-1:0] pin_first_oe_o,           // Pin enable, first location
	output logic      [NUM_CH-1:0] pin_second_o,             // Pin drive, second location
	output logic      [NUM_CH-1:0] pin_second_oe_o           // Pin enable, second location
);
	typedef struct packed {
		logic [7:0]        opts;
		logic              once_done;
		logic              wd_en;
		sysopt_svc_t       svc;
		logic              ack;
		logic [31:0]       rdata;
		logic              sys_rst;
		logic [NUM_CH-1:0] first_s1;
		logic [NUM_CH-1:0] first_s2;
		logic [NUM_CH-1:0] second_s1;
		logic [NUM_CH-1:0] second_s2;
		logic              cmp_s1;
		logic              cmp_s2;
		logic [NUM_CH-1:0] first_o;
		logic [NUM_CH-1:0] first_oe;
		logic [NUM_CH-1:0] second_o;
		logic [NUM_CH-1:0] second_oe;
		logic [NUM_CH-1:0] tin;
	} sysopt_state_t;

	sysopt_state_t     st;
	sysopt_state_t     next_st;
	sysopt_wdog_if     wd_bus ();

	logic              req;
	logic              wr_lane0;
	logic              srs_write;
	logic              service_done;
	logic [7:0]        opt_mask;
	logic [NUM_CH-1:0] route_first_o;
	logic [NUM_CH-1:0] route_first_oe;
	logic [NUM_CH-1:0] route_second_o;
	logic [NUM_CH-1:0] route_second_oe;
	logic [NUM_CH-1:0] route_in;

	// Classic cycle: one ack per request, gap cycle forced by !st.ack
	assign req       = wb_cyc_i && wb_stb_i && !st.ack;
	assign wr_lane0  = req && wb_we_i && wb_sel_i[0];
	assign srs_write = wr_lane0 && (wb_adr_i == ADR_RESET_STAT);
	assign service_done = srs_write && (st.svc == SVC_ARMED)
	                      && (wb_dat_i[7:0] == SERVICE_SECOND);

	// Write-once bits drop out of the mask after the first write
	assign opt_mask = st.once_done ? (OPT_WRITE_MASK & ~OPT_ONCE_MASK) : OPT_WRITE_MASK;

	// Channel order 0..3 matches option bits 0..3, so bit i picks location
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_route
			logic alt;
			assign alt = st.opts[ch];
			assign route_first_o[ch]   = !alt && tmr_out_i[ch];
			assign route_first_oe[ch]  = !alt && tmr_oe_i[ch];
			assign route_second_o[ch]  = alt && tmr_out_i[ch];
			assign route_second_oe[ch] = alt && tmr_oe_i[ch];
			if (ch == 0) begin : g_cap
				// Comparator takes over the capture input, the pin stays routed
				assign route_in[ch] = st.opts[BIT_CMP_CAPTURE] ? st.cmp_s2
				                      : (alt ? st.second_s2[ch] : st.first_s2[ch]);
			end else begin : g_pin
				assign route_in[ch] = alt ? st.second_s2[ch] : st.first_s2[ch];
			end
		end
	endgenerate

	always_comb begin
		next_st = st;
		next_st.ack = req;
		next_st.sys_rst = wd_bus.timeout || wd_bus.early_write;

		// Pin and comparator inputs pass two flops before use
		next_st.first_s1  = pin_first_i;
		next_st.first_s2  = st.first_s1;
		next_st.second_s1 = pin_second_i;
		next_st.second_s2 = st.second_s1;
		next_st.cmp_s1    = analog_comparator_i;
		next_st.cmp_s2    = st.cmp_s1;

		next_st.first_o   = route_first_o;
		next_st.first_oe  = route_first_oe;
		next_st.second_o  = route_second_o;
		next_st.second_oe = route_second_oe;
		next_st.tin       = route_in;

		if (wr_lane0) begin
			case (wb_adr_i)
				ADR_OPTIONS: begin
					next_st.opts = (st.opts & ~opt_mask) | (wb_dat_i[7:0] & opt_mask);
					next_st.once_done = 1'b1;
				end
				ADR_WDOG_CTRL: begin
					next_st.wd_en = wb_dat_i[CTRL_BIT_WD_EN];
				end
				ADR_RESET_STAT: begin
					// Service pair tracker; a stray value restarts the pair
					case (st.svc)
						SVC_IDLE: begin
							next_st.svc = (wb_dat_i[7:0] == SERVICE_FIRST) ? SVC_ARMED : SVC_IDLE;
						end
						SVC_ARMED: begin
							next_st.svc = (wb_dat_i[7:0] == SERVICE_FIRST) ? SVC_ARMED : SVC_IDLE;
						end
						default: begin
							next_st.svc = SVC_IDLE;
						end
					endcase
				end
				default: begin
				end
			endcase
		end

		if (req && !wb_we_i) begin
			case (wb_adr_i)
				ADR_OPTIONS: begin
					next_st.rdata = {24'h000000, st.opts};
				end
				ADR_RESET_STAT: begin
					next_st.rdata = 32'h00000000;
					next_st.rdata[STAT_BIT_OPEN]  = wd_bus.window_open;
					next_st.rdata[STAT_BIT_ARMED] = (st.svc == SVC_ARMED);
				end
				ADR_WDOG_CTRL: begin
					next_st.rdata = 32'h00000000;
					next_st.rdata[CTRL_BIT_WD_EN] = st.wd_en;
				end
				default: begin
					next_st.rdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st       <= '0;
			st.opts  <= OPT_RESET;
			st.svc   <= SVC_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign wd_bus.enable       = st.wd_en;
	assign wd_bus.bus_clk_sel  = st.opts[BIT_CLK_SEL];
	assign wd_bus.window_mode  = st.opts[BIT_WINDOW] && st.opts[BIT_CLK_SEL];
	assign wd_bus.srs_write    = srs_write;
	assign wd_bus.service_done = service_done;

	sysopt_wdog #(
		.TICK_CYCLES   (LP_TICK_CYCLES_P),
		.TIMEOUT_TICKS (WDOG_TIMEOUT_TICKS_P)
	) u_wdog (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.wd    (wd_bus)
	);

	assign wb_dat_o                 = st.rdata;
	assign wb_ack_o                 = st.ack;
	assign system_reset_o           = st.sys_rst;
	assign watchdog_clock_select_o  = st.opts[BIT_CLK_SEL];
	assign watchdog_window_enable_o = st.opts[BIT_WINDOW];
	assign tmr_in_o                 = st.tin;
	assign pin_first_o              = st.first_o;
	assign pin_first_oe_o           = st.first_oe;
	assign pin_second_o             = st.second_o;
	assign pin_second_oe_o          = st.second_oe;
endmodule

/* design/sysopt_pkg.sv */
// Constants, offsets and types for the system options register bank.
// Assumes a 100 MHz bus clock and a classic Wishbone master.
// Behaviour
// - Write-once option bits take the first write after reset, later writes ignored.
// - Bit 7 picks watchdog counting source: 1 kHz low-power tick or bus clock.
// - Bit 6 is write-once; window mode applies only while bit 7 is 1.
// - In window mode any reset-status write in the first 75% forces system reset.
// - Bit 4 set feeds comparator output into timer one capture channel 0.
// - Bit 3 routes timer two channel 1 to port B pin 4 or port A pin 7.
// - Bit 2 puts timer two channel 0 on port A pin 1 or pin 6.
// - Bit 1 puts timer one channel 1 on port B pin 5 or port C pin 1.
// - Bit 0 routes timer one channel 0 to port A pin 0 or port C pin 0.
package sysopt_pkg;
	localparam int          ADR_W           = 8;
	localparam logic [7:0]  ADR_OPTIONS     = 8'h00;
	localparam logic [7:0]  ADR_RESET_STAT  = 8'h04;
	localparam logic [7:0]  ADR_WDOG_CTRL   = 8'h08;
	localparam int          BIT_CLK_SEL     = 7;
	localparam int          BIT_WINDOW      = 6;
	localparam int          BIT_CMP_CAPTURE = 4;
	localparam logic [7:0]  OPT_RESET       = 8'h00;
	localparam logic [7:0]  OPT_WRITE_MASK  = 8'hDF;
	localparam logic [7:0]  OPT_ONCE_MASK   = 8'hC0;
	localparam logic [7:0]  SERVICE_FIRST   = 8'h55;
	localparam logic [7:0]  SERVICE_SECOND  = 8'hAA;
	localparam int          CTRL_BIT_WD_EN  = 0;
	localparam int          STAT_BIT_OPEN   = 0;
	localparam int          STAT_BIT_ARMED  = 1;
	localparam int          NUM_CH          = 4;
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned LP_PERIOD_NS    = 1000000;
	localparam int unsigned LP_TICK_CYCLES  = LP_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned WDOG_TIMEOUT_DEFAULT = 1024;
	typedef enum logic [1:0] {
		SVC_IDLE  = 2'h0,
		SVC_ARMED = 2'h1
	} sysopt_svc_t;
endpackage

/* design/sysopt_wdog_if.sv */
// Carrier between the option register logic and the watchdog counter.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface sysopt_wdog_if;
	logic enable;
	logic bus_clk_sel;
	logic window_mode;
	logic srs_write;
	logic service_done;
	logic timeout;
	logic early_write;
	logic window_open;
	modport ctrl (output enable, bus_clk_sel, window_mode, srs_write, service_done,
	              input timeout, early_write, window_open);
	modport wdog (input enable, bus_clk_sel, window_mode, srs_write, service_done,
	              output timeout, early_write, window_open);
endinterface

/* design/sysopt_wdog.sv */
// Watchdog counter with optional service window.
// Assumes strobes from the controller are one-cycle pulses on clk_i.
`timescale 1ns/1ps
module sysopt_wdog import sysopt_pkg::*; #(
	parameter int unsigned TICK_CYCLES   = LP_TICK_CYCLES,
	parameter int unsigned TIMEOUT_TICKS = WDOG_TIMEOUT_DEFAULT
) (
	input  wire logic        clk_i, // Bus clock
	input  wire logic        rst_i, // Synchronous reset
	sysopt_wdog_if.wdog      wd     // Controller side
);
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
	localparam logic [31:0] CNT_LAST  = 32'(TIMEOUT_TICKS - 1);
	localparam logic [31:0] WIN_START = 32'(TIMEOUT_TICKS - TIMEOUT_TICKS / 4);

	typedef struct packed {
		logic [31:0] presc;
		logic [31:0] count;
		logic        timeout;
		logic        early;
		logic        open;
	} sysopt_wd_state_t;

	sysopt_wd_state_t st;
	sysopt_wd_state_t next_st;
	logic             tick;

	always_comb begin
		next_st = st;
		next_st.timeout = 1'b0;
		next_st.early = 1'b0;
		tick = wd.bus_clk_sel || (st.presc == TICK_LAST);
		if (!wd.enable) begin
			next_st.presc = '0;
			next_st.count = '0;
		end else begin
			next_st.presc = tick ? '0 : st.presc + 32'h1;
			if (wd.window_mode && wd.srs_write && !st.open) begin
				next_st.early = 1'b1;
				next_st.count = '0;
				next_st.presc = '0;
			end else if (wd.service_done) begin
				next_st.count = '0;
				next_st.presc = '0;
			end else if (tick) begin
				if (st.count == CNT_LAST) begin
					next_st.timeout = 1'b1;
					next_st.count = '0;
				end else begin
					next_st.count = st.count + 32'h1;
				end
			end
		end
		// Final quarter of the period is the legal service window
		next_st.open = (next_st.count >= WIN_START);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign wd.timeout     = st.timeout;
	assign wd.early_write = st.early;
	assign wd.window_open = st.open;
endmodule

/* testbench/sysopt_top_props.sv */
// Concurrent checks on the option register bank ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sysopt_top_props import sysopt_pkg::*; (
	input wire logic              clk_i,                    // Clock
	input wire logic              rst_i,                    // Reset
	input wire logic              wb_cyc_i,                 // Cycle
	input wire logic              wb_stb_i,                 // Strobe
	input wire logic              wb_we_i,                  // Write
	input wire logic [ADR_W-1:0]  wb_adr_i,                 // Address
	input wire logic [31:0]       wb_dat_o,                 // Read data
	input wire logic              wb_ack_o,                 // Ack
	input wire logic              system_reset_o,           // Reset pulse
	input wire logic              watchdog_clock_select_o,  // Bit 7
	input wire logic              watchdog_window_enable_o, // Bit 6
	input wire logic [NUM_CH-1:0] tmr_out_i,                // Timer drive
	input wire logic [NUM_CH-1:0] tmr_oe_i,                 // Timer enable
	input wire logic [NUM_CH-1:0] pin_first_o,              // First drive
	input wire logic [NUM_CH-1:0] pin_first_oe_o,           // First enable
	input wire logic [NUM_CH-1:0] pin_second_oe_o           // Second enable
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire logic req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic opt_wr = req && wb_we_i && wb_adr_i == ADR_OPTIONS;
	wire logic mapped = wb_adr_i inside {ADR_OPTIONS, ADR_RESET_STAT, ADR_WDOG_CTRL};

	a_ack_answer: assert property (req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle after request");
	a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0) else $error("unmapped read");
	a_clksel_write: assert property ($changed(watchdog_clock_select_o) |-> $past(opt_wr)) else $error("bit 7 moved");
	a_window_write: assert property ($changed(watchdog_window_enable_o) |-> $past(opt_wr)) else $error("bit 6 moved");
	a_reset_clears: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !system_reset_o
		&& !watchdog_clock_select_o && !watchdog_window_enable_o) else $error("outputs not cleared");
	a_pulse_single: assert property (system_reset_o |=> !system_reset_o) else $error("reset pulse too long");
	a_oe_exclusive: assert property ((pin_first_oe_o & pin_second_oe_o) == 4'h0) else $error("both pins driven");
	a_oe_follow: assert property (!$past(rst_i) |-> (pin_first_oe_o | pin_second_oe_o) == $past(tmr_oe_i))
		else $error("pin enable lost");
	a_drive_follow: assert property (!$past(rst_i) |-> (pin_first_o & pin_first_oe_o)
		== ($past(tmr_out_i) & pin_first_oe_o)) else $error("pin drive wrong");
endmodule
bind sysopt_top sysopt_top_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .system_reset_o, .watchdog_clock_select_o, .watchdog_window_enable_o, .tmr_out_i, .tmr_oe_i,
	.pin_first_o, .pin_first_oe_o, .pin_second_oe_o);

/* testbench/system_options_config_tb.sv */
// Self-checking bench for the option register bank.
// Assumes sysopt_top with short tick and timeout parameters.
`timescale 1ns/1ps
module system_options_config_tb import sysopt_pkg::*;;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, system_reset_o;
	logic watchdog_clock_select_o, watchdog_window_enable_o, analog_comparator_i = 0;
	logic [ADR_W-1:0]  wb_adr_i = '0;
	logic [31:0]       wb_dat_i = '0, wb_dat_o;
	logic [NUM_CH-1:0] tmr_out_i = '0, tmr_oe_i = '0, pin_first_i = '0, pin_second_i = '0;
	logic [NUM_CH-1:0] tmr_in_o, pin_first_o, pin_first_oe_o, pin_second_o, pin_second_oe_o;
	logic [7:0]        q[$];
	logic [15:0]       lfsr = 16'h1;
	int                n_errors = 0, checks = 0, n_rst = 0;

	sysopt_top #(.LP_TICK_CYCLES_P(4), .WDOG_TIMEOUT_TICKS_P(64)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .system_reset_o,
		.watchdog_clock_select_o, .watchdog_window_enable_o, .analog_comparator_i, .tmr_out_i, .tmr_oe_i,
		.tmr_in_o, .pin_first_i, .pin_second_i, .pin_first_o, .pin_first_oe_o, .pin_second_o, .pin_second_oe_o);

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic conclude();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Read data d is the expected value, noted before the request goes out
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, w, a};
		wb_dat_i <= {24'h0, d};
		if (!w)
			q.push_back(d);
		// No cycle budget here: only the bench watchdog ends a hung wait
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask

	task automatic do_reset(input int c);
		rst_i <= 1'b1;
		repeat (c) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask

	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && !wb_we_i && q.size() > 0)
			chk("read", q.pop_front(), wb_dat_o[7:0]);
		if (system_reset_o === 1'b1)
			n_rst++;
	end

	initial begin
		#300000;
		n_errors++;
		conclude();
	end

	initial begin
		logic [3:0] s;
		logic [3:0] ti;
		logic       ac;
		do_reset(10);
		bus(0, ADR_OPTIONS, OPT_RESET);
		bus(1, ADR_OPTIONS, 8'h80);
		bus(1, 8'h0C, 8'hFF);
		bus(0, 8'h0C, 8'h00);
		chk("clk_sel", 8'h01, watchdog_clock_select_o);
		for (int k = 0; k < 16; k++) begin
			s = k[3:0];
			ac = k[0] ^ k[2];
			lfsr = lfsr_next(lfsr);
			{tmr_out_i, tmr_oe_i, pin_first_i} <= lfsr[11:0];
			pin_second_i <= ~lfsr[11:8];
			analog_comparator_i <= lfsr[12];
			// Bits 6 and 5 ask for a change that must not land
			bus(1, ADR_OPTIONS, {3'b111, ac, s});
			bus(0, ADR_OPTIONS, {3'b100, ac, s});
			repeat (4) @(posedge clk_i);
			ti = (pin_first_i & ~s) | (pin_second_i & s);
			if (ac)
				ti[0] = analog_comparator_i;
			chk("first_oe", tmr_oe_i & ~s, pin_first_oe_o);
			chk("second_oe", tmr_oe_i & s, pin_second_oe_o);
			chk("first_drv", tmr_out_i & tmr_oe_i & ~s, pin_first_o & pin_first_oe_o);
			chk("second_drv", tmr_out_i & tmr_oe_i & s, pin_second_o & pin_second_oe_o);
			chk("tmr_in", ti, tmr_in_o);
		end
		do_reset(2);
		bus(1, ADR_OPTIONS, 8'hC0);
		bus(1, ADR_WDOG_CTRL, 8'h01);
		bus(1, ADR_RESET_STAT, 8'h00);
		// Lands inside the last quarter of a 64-cycle period
		repeat (50) @(posedge clk_i);
		bus(0, ADR_RESET_STAT, 8'h01);
		bus(1, ADR_RESET_STAT, SERVICE_FIRST);
		bus(1, ADR_RESET_STAT, SERVICE_SECOND);
		bus(1, ADR_WDOG_CTRL, 8'h00);
		repeat (8) @(posedge clk_i);
		chk("resets", 8'h01, n_rst[7:0]);
		do_reset(2);
		bus(1, ADR_OPTIONS, 8'h40);
		bus(1, ADR_WDOG_CTRL, 8'h01);
		bus(1, ADR_RESET_STAT, 8'h00);
		// Slow tick: 64 ticks of 4 cycles; a bus-clock count would already have expired
		repeat (200) @(posedge clk_i);
		chk("resets", 8'h01, n_rst[7:0]);
		repeat (100) @(posedge clk_i);
		chk("resets", 8'h02, n_rst[7:0]);
		bus(1, ADR_WDOG_CTRL, 8'h00);
		repeat (8) @(posedge clk_i);
		chk("win_en", 8'h01, watchdog_window_enable_o);
		chk("resets", 8'h02, n_rst[7:0]);
		conclude();
	end
endmodule
